// ==== wcts_top.sv ====
// Wake source flags, wake input levels and CAN timeout / selective wake error status.
`timescale 1ns/10ps

module wcts_top #(
  parameter int INT_PULSE_CYCLES = wcts_pkg::INT_PULSE_CYCLES,
  parameter int SWK_ERR_LIMIT = wcts_pkg::SWK_ERR_LIMIT
) (
  input wire logic clk, // System clock, 20 MHz.
  input wire logic rst_n, // Power-on or soft reset, synchronous, active low.
  input wire logic restart_rst, // Restart reset, one-cycle pulse.
  input wire wcts_pkg::wcts_mode_t mode, // Current operating mode.
  input wire wcts_pkg::wcts_wake_evt_t wake_evt, // Wake event pulses.
  input wire logic [wcts_pkg::WAKE_INPUTS-1:0] wake_level_in, // Wake input pin levels.
  input wire logic [wcts_pkg::WAKE_INPUTS-1:0] wake_cyclic_mode, // Cyclic operation per input.
  input wire logic [wcts_pkg::WAKE_INPUTS-1:0] wake_sample_strobe, // Cyclic sampling instants.
  input wire logic selective_wake_enable_bit, // Selective wake enabled.
  input wire logic can_silent_indication, // CAN bus silence detected.
  input wire logic can_timeout_irq_mask, // 1 lets the timeout interrupt out.
  input wire logic swk_config_error, // Selective wake configuration error pulse.
  input wire logic swk_error_event, // Selective wake error counter increment pulse.
  input wire logic swk_error_count_clear, // Selective wake error counter reset pulse.
  input wire wcts_pkg::wcts_acc_req_t acc_req, // Register read or read-clear request.
  output wcts_pkg::wcts_acc_rsp_t acc_rsp, // Register answer.
  output logic interrupt_out_n, // Interrupt output, active low pulse.
  output logic can_timeout_flag, // CAN timeout flag.
  output logic selective_wake_system_error // Selective wake system error flag.
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    INT_IDLE,
    INT_PULSE
  } wcts_int_state_t;

  localparam int INT_CNT_W = $clog2(INT_PULSE_CYCLES + 1);
  localparam logic [INT_CNT_W-1:0] INT_LOAD = INT_CNT_W'(INT_PULSE_CYCLES - 1);
  localparam logic [wcts_pkg::SWK_CNT_W-1:0] SWK_OVERFLOW = wcts_pkg::SWK_CNT_W'(SWK_ERR_LIMIT + 1);

  logic [wcts_pkg::REG_W-1:0] wake_flags_reg;
  logic [wcts_pkg::REG_W-1:0] wake_flags_next;
  logic can_timeout_reg;
  logic can_timeout_next;
  logic selective_wake_system_error_reg;
  logic selective_wake_system_error_next;
  logic clear_lock_reg;
  logic clear_lock_next;
  logic silent_prev_reg;
  logic [wcts_pkg::SWK_CNT_W-1:0] swk_cnt_reg;
  logic [wcts_pkg::SWK_CNT_W-1:0] swk_cnt_next;
  logic fail_safe_prev_reg;
  wcts_int_state_t int_state_reg;
  wcts_int_state_t int_state_next;
  logic [INT_CNT_W-1:0] int_cnt_reg;
  logic [INT_CNT_W-1:0] int_cnt_next;
  logic int_n_reg;
  logic int_n_next;
  wcts_pkg::wcts_acc_rsp_t rsp_reg;
  wcts_pkg::wcts_acc_rsp_t rsp_next;
  logic [wcts_pkg::WAKE_INPUTS-1:0] level_q;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  wire sel_bus = acc_req.valid && (acc_req.addr == wcts_pkg::ADDR_BUS_STATUS);
  wire sel_flags = acc_req.valid && (acc_req.addr == wcts_pkg::ADDR_WAKE_SOURCE_FLAGS);
  wire sel_levels = acc_req.valid && (acc_req.addr == wcts_pkg::ADDR_WAKE_INPUT_LEVELS);
  wire clr_bus = sel_bus && acc_req.clear;
  wire clr_flags = sel_flags && acc_req.clear;
  wire swk_on = selective_wake_enable_bit;
  wire irq_mode = (mode == wcts_pkg::MODE_NORMAL) || (mode == wcts_pkg::MODE_STOP);
  wire track_en = (mode == wcts_pkg::MODE_NORMAL) || (mode == wcts_pkg::MODE_STOP) ||
                  (mode == wcts_pkg::MODE_INIT) || (mode == wcts_pkg::MODE_RESTART);
  wire fail_safe_entry = (mode == wcts_pkg::MODE_FAIL_SAFE) && !fail_safe_prev_reg;
  // Set only while selective wake is enabled.
  wire silent_rise = can_silent_indication && !silent_prev_reg;
  wire timeout_set = swk_on && silent_rise;
  // Interrupt only when unmasked in Stop or Normal.
  wire irq_fire = timeout_set && can_timeout_irq_mask && irq_mode;
  wire int_fall = (int_state_reg == INT_IDLE) && irq_fire;
  wire swk_overflow = (swk_cnt_reg >= SWK_OVERFLOW);

  // Places a bit at a given position of a register-wide word.
  function automatic logic [wcts_pkg::REG_W-1:0] bit_at(input logic v, input int pos);
    logic [wcts_pkg::REG_W-1:0] w;
    w = '0;
    w[pos] = v;
    return w;
  endfunction

  // Wake event bits at their documented positions.
  wire [wcts_pkg::REG_W-1:0] wake_set =
    bit_at(wake_evt.lin, wcts_pkg::BIT_LIN_WAKE) |
    bit_at(wake_evt.can, wcts_pkg::BIT_CAN_WAKE) |
    bit_at(wake_evt.timer_two, wcts_pkg::BIT_TIMER_TWO_WAKE) |
    bit_at(wake_evt.timer_one, wcts_pkg::BIT_TIMER_ONE_WAKE) |
    {{(wcts_pkg::REG_W - wcts_pkg::WAKE_INPUTS){1'b0}}, wake_evt.wk};

  // Timeout and error bits of the bus status word.
  wire [wcts_pkg::REG_W-1:0] bus_word =
    bit_at(can_timeout_reg, wcts_pkg::BIT_CAN_TIMEOUT) |
    bit_at(selective_wake_system_error_reg, wcts_pkg::BIT_SWK_SELECTIVE_WAKE_SYSTEM_ERROR);

  // Level bits, upper bits forced to zero.
  wire [wcts_pkg::REG_W-1:0] level_word =
    {{(wcts_pkg::REG_W - wcts_pkg::WAKE_INPUTS){1'b0}}, level_q} & wcts_pkg::WAKE_LEVELS_VALID;

  // ----------------------------------------------------------------------
  // Wake source flags
  // ----------------------------------------------------------------------
  // Sticky until cleared; a new event beats the clear.
  // Fail-safe entry clears the whole register.
  always_comb begin
    wake_flags_next = wake_flags_reg;
    if (fail_safe_entry) begin
      wake_flags_next = wcts_pkg::WAKE_FLAGS_RESET;
    end else if (clr_flags) begin
      wake_flags_next = wake_set & wcts_pkg::WAKE_FLAGS_VALID;
    end else begin
      wake_flags_next = (wake_flags_reg | wake_set) & wcts_pkg::WAKE_FLAGS_VALID;
    end
  end

  // ----------------------------------------------------------------------
  // CAN timeout flag and its clear lock
  // ----------------------------------------------------------------------
  // The lock is armed only for an unmasked timeout that finds a pulse already running, never for a masked one;
  // otherwise a masked timeout could never be cleared at all.
  always_comb begin
    can_timeout_next = can_timeout_reg;
    clear_lock_next = clear_lock_reg;
    // Clear ignored while the lock stands.
    if (clr_bus && !clear_lock_reg) begin
      can_timeout_next = 1'b0;
    end
    // Set on silence start, held after silence ends.
    if (timeout_set) begin
      can_timeout_next = 1'b1;
    end
    // Lock released by the interrupt falling edge.
    if (int_fall) begin
      clear_lock_next = 1'b0;
    end else if (timeout_set && !can_timeout_reg && irq_fire) begin
      clear_lock_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Selective wake system error
  // ----------------------------------------------------------------------
  always_comb begin
    selective_wake_system_error_next = selective_wake_system_error_reg;
    swk_cnt_next = swk_cnt_reg;
    if (swk_error_count_clear) begin
      swk_cnt_next = '0;
    end else if (swk_error_event && !swk_overflow) begin
      swk_cnt_next = swk_cnt_reg + 1'b1;
    end
    // Flag frozen while selective wake is off.
    if (swk_on) begin
      if (clr_bus) begin
        selective_wake_system_error_next = 1'b0;
      end
      // Config error or counter beyond the limit.
      if (swk_config_error || swk_overflow) begin
        selective_wake_system_error_next = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt pulse generator
  // ----------------------------------------------------------------------
  always_comb begin
    int_state_next = int_state_reg;
    int_cnt_next = int_cnt_reg;
    int_n_next = int_n_reg;
    case (int_state_reg)
      INT_IDLE: begin
        int_n_next = 1'b1;
        // Pulse starts with the flag setting.
        if (irq_fire) begin
          int_state_next = INT_PULSE;
          int_cnt_next = INT_LOAD;
          int_n_next = 1'b0;
        end
      end
      INT_PULSE: begin
        if (int_cnt_reg == '0) begin
          int_state_next = INT_IDLE;
          int_n_next = 1'b1;
        end else begin
          int_cnt_next = int_cnt_reg - 1'b1;
        end
      end
      default: begin
        int_state_next = INT_IDLE;
        int_n_next = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Register answers
  // ----------------------------------------------------------------------
  // Unmapped and reserved positions answer zero.
  always_comb begin
    rsp_next.ack = acc_req.valid;
    rsp_next.rdata = '0;
    if (sel_bus) begin
      rsp_next.rdata = bus_word;
    end else if (sel_flags) begin
      rsp_next.rdata = wake_flags_reg & wcts_pkg::WAKE_FLAGS_VALID;
    end else if (sel_levels) begin
      rsp_next.rdata = level_word;
    end
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_flags_reg <= wcts_pkg::WAKE_FLAGS_RESET;
      can_timeout_reg <= 1'b0;
      selective_wake_system_error_reg <= 1'b0;
      clear_lock_reg <= 1'b0;
      swk_cnt_reg <= '0;
    end else if (restart_rst) begin
      wake_flags_reg <= wake_flags_reg & wcts_pkg::WAKE_FLAGS_RESTART_KEEP;
      clear_lock_reg <= 1'b0;
    end else begin
      wake_flags_reg <= wake_flags_next;
      can_timeout_reg <= can_timeout_next;
      selective_wake_system_error_reg <= selective_wake_system_error_next;
      clear_lock_reg <= clear_lock_next;
      swk_cnt_reg <= swk_cnt_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      silent_prev_reg <= 1'b0;
      fail_safe_prev_reg <= 1'b0;
      int_state_reg <= INT_IDLE;
      int_cnt_reg <= '0;
      int_n_reg <= 1'b1;
      rsp_reg <= '0;
    end else begin
      silent_prev_reg <= can_silent_indication;
      fail_safe_prev_reg <= (mode == wcts_pkg::MODE_FAIL_SAFE);
      int_state_reg <= int_state_next;
      int_cnt_reg <= int_cnt_next;
      int_n_reg <= int_n_next;
      rsp_reg <= rsp_next;
    end
  end

  // ----------------------------------------------------------------------
  // Level register
  // ----------------------------------------------------------------------
  wcts_level_sampler #(
    .N(wcts_pkg::WAKE_INPUTS)
  ) u_levels (
    .clk(clk),
    .rst_n(rst_n),
    .restart_rst(restart_rst),
    .track_en(track_en),
    .level_in(wake_level_in),
    .cyclic_mode(wake_cyclic_mode),
    .sample_strobe(wake_sample_strobe),
    .level_out(level_q)
  );

  assign acc_rsp = rsp_reg;
  assign interrupt_out_n = int_n_reg;
  assign can_timeout_flag = can_timeout_reg;
  assign selective_wake_system_error = selective_wake_system_error_reg;

endmodule

// ==== wcts_pkg.sv ====
// Shared constants, modes and carrier types of the wake and CAN timeout status block.
package wcts_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int ADDR_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_BUS_STATUS = 7'h43;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_SOURCE_FLAGS = 7'h44;
  localparam logic [ADDR_W-1:0] ADDR_WAKE_INPUT_LEVELS = 7'h45;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_CAN_TIMEOUT = 4;
  localparam int BIT_SWK_SELECTIVE_WAKE_SYSTEM_ERROR = 3;
  localparam int BIT_LIN_WAKE = 10;
  localparam int BIT_CAN_WAKE = 9;
  localparam int BIT_TIMER_TWO_WAKE = 8;
  localparam int BIT_TIMER_ONE_WAKE = 7;
  localparam int WAKE_INPUTS = 4;

  // ----------------------------------------------------------------------
  // Reset values and restart keep masks
  // ----------------------------------------------------------------------
  localparam logic [REG_W-1:0] WAKE_FLAGS_RESET = 16'h0000;
  localparam logic [REG_W-1:0] WAKE_FLAGS_RESTART_KEEP = 16'h0782;
  localparam logic [REG_W-1:0] WAKE_LEVELS_RESET = 16'h0000;
  localparam logic [REG_W-1:0] WAKE_LEVELS_RESTART_KEEP = 16'h0002;
  localparam logic [REG_W-1:0] WAKE_FLAGS_VALID = 16'h078f;
  localparam logic [REG_W-1:0] WAKE_LEVELS_VALID = 16'h000f;

  // ----------------------------------------------------------------------
  // Timing and counts
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int INT_PULSE_US = 100;
  localparam int INT_PULSE_CYCLES = (INT_PULSE_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam int SWK_ERR_LIMIT = 32;
  localparam int SWK_CNT_W = 6;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_STOP,
    MODE_INIT,
    MODE_RESTART,
    MODE_SLEEP,
    MODE_FAIL_SAFE
  } wcts_mode_t;

  typedef struct packed {
    logic lin;
    logic can;
    logic timer_two;
    logic timer_one;
    logic [WAKE_INPUTS-1:0] wk;
  } wcts_wake_evt_t;

  typedef struct packed {
    logic valid;
    logic clear;
    logic [ADDR_W-1:0] addr;
  } wcts_acc_req_t;

  typedef struct packed {
    logic ack;
    logic [REG_W-1:0] rdata;
  } wcts_acc_rsp_t;

endpackage

// ==== wcts_level_sampler.sv ====
// Wake input level tracker: live in active modes, sampled under cyclic operation.
`timescale 1ns/10ps

module wcts_level_sampler #(
  parameter int N = wcts_pkg::WAKE_INPUTS
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic restart_rst, // Restart reset pulse.
  input wire logic track_en, // Mode allows level updates.
  input wire logic [N-1:0] level_in, // Wake input levels.
  input wire logic [N-1:0] cyclic_mode, // Input in cyclic sense or wake.
  input wire logic [N-1:0] sample_strobe, // Cyclic sampling instant.
  output logic [N-1:0] level_out // Held or live level.
);

  logic [N-1:0] level_reg;
  logic [N-1:0] level_next;
  logic [N-1:0] keep_mask;

  assign keep_mask = wcts_pkg::WAKE_LEVELS_RESTART_KEEP[N-1:0];

  // Live tracking, sampled value under cyclic operation.
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < N; i++) begin
      if (cyclic_mode[i]) begin
        if (sample_strobe[i]) begin
          level_next[i] = level_in[i];
        end
      end else if (track_en) begin
        level_next[i] = level_in[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_reg <= wcts_pkg::WAKE_LEVELS_RESET[N-1:0];
    end else if (restart_rst) begin
      level_reg <= level_reg & keep_mask;
    end else begin
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule

// ==== wcts_host_model.sv ====
// Host controller model that issues register reads and read-clears.
`timescale 1ns/10ps

module wcts_host_model (
  input wire logic clk, // System clock.
  output wcts_pkg::wcts_acc_req_t acc_req, // Request to the block.
  input wire wcts_pkg::wcts_acc_rsp_t acc_rsp // Answer from the block.
);
  initial acc_req = '0;

  // The request stands for one cycle only, as a second cycle would count as a second access.
  // A missing acknowledge hands back unknown data so that no comparison can pass on it.
  task automatic access(input logic [wcts_pkg::ADDR_W-1:0] addr, input logic clr, output logic [15:0] data);
    @(posedge clk);
    acc_req <= '{valid: 1'b1, clear: clr, addr: addr};
    @(posedge clk);
    acc_req <= '0;
    #1;
    data = acc_rsp.ack ? acc_rsp.rdata : 16'hxxxx;
  endtask
endmodule

// ==== wcts_top_assertions.sv ====
// Concurrent checks on the ports of the wake and CAN timeout status block.
`timescale 1ns/10ps

module wcts_top_assertions #(
  parameter int INT_PULSE_CYCLES = 4
) (
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic restart_rst, // Restart reset.
  input wire wcts_pkg::wcts_mode_t mode, // Operating mode.
  input wire logic selective_wake_enable_bit, // Selective wake on.
  input wire logic can_silent_indication, // Bus silence.
  input wire logic can_timeout_irq_mask, // Interrupt allowed.
  input wire logic swk_config_error, // Config error.
  input wire wcts_pkg::wcts_acc_req_t acc_req, // Request.
  input wire wcts_pkg::wcts_acc_rsp_t acc_rsp, // Answer.
  input wire logic interrupt_out_n, // Interrupt, active low.
  input wire logic can_timeout_flag, // Timeout flag.
  input wire logic selective_wake_system_error // Error flag.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  int low_cnt;
  wire logic is_run = (mode == wcts_pkg::MODE_NORMAL) || (mode == wcts_pkg::MODE_STOP);
  wire logic clr_bus = acc_req.valid && acc_req.clear && (acc_req.addr == wcts_pkg::ADDR_BUS_STATUS);
  wire logic [15:0] legal = (acc_req.addr == wcts_pkg::ADDR_WAKE_SOURCE_FLAGS) ? wcts_pkg::WAKE_FLAGS_VALID :
    (acc_req.addr == wcts_pkg::ADDR_WAKE_INPUT_LEVELS) ? wcts_pkg::WAKE_LEVELS_VALID :
    (acc_req.addr == wcts_pkg::ADDR_BUS_STATUS) ? 16'h0018 : 16'h0000;

  // Counts how long the interrupt line has been low, so the pulse width can be judged at its end.
  always_ff @(posedge clk) begin
    low_cnt <= (!rst_n || interrupt_out_n) ? 0 : low_cnt + 1;
  end

  sequence s_silent_rise;
    $rose(can_silent_indication) && selective_wake_enable_bit && !restart_rst;
  endsequence
  sequence s_pulse_start;
    $fell(interrupt_out_n);
  endsequence

  property p_to_enable;
    $rose(can_timeout_flag) |-> $past(selective_wake_enable_bit);
  endproperty
  property p_to_set;
    s_silent_rise |=> can_timeout_flag;
  endproperty
  property p_to_hold;
    can_timeout_flag && !clr_bus |=> can_timeout_flag;
  endproperty
  property p_irq_set;
    $rose(can_timeout_flag) && $past(can_timeout_irq_mask) && $past(is_run) && $past(interrupt_out_n)
      |-> s_pulse_start;
  endproperty
  property p_irq_cause;
    s_pulse_start |-> $rose(can_timeout_flag);
  endproperty
  property p_irq_len;
    $rose(interrupt_out_n) |-> low_cnt == INT_PULSE_CYCLES;
  endproperty
  property p_ack;
    acc_req.valid |=> acc_rsp.ack;
  endproperty
  property p_res;
    acc_req.valid |=> (acc_rsp.rdata & ~$past(legal)) == 16'h0000;
  endproperty
  property p_sys_frozen;
    !selective_wake_enable_bit |=> $stable(selective_wake_system_error);
  endproperty
  property p_sys_cfg;
    selective_wake_enable_bit && swk_config_error && !restart_rst |=> selective_wake_system_error;
  endproperty

  a_to_enable: assert property (p_to_enable) else $error("timeout flag set while disabled");
  a_to_set: assert property (p_to_set) else $error("timeout flag missed silence");
  a_to_hold: assert property (p_to_hold) else $error("timeout flag dropped");
  a_irq_set: assert property (p_irq_set) else $error("interrupt missing");
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without timeout");
  a_irq_len: assert property (p_irq_len) else $error("interrupt pulse width wrong");
  a_ack: assert property (p_ack) else $error("no acknowledge");
  a_res: assert property (p_res) else $error("reserved bit set");
  a_sys_frozen: assert property (p_sys_frozen) else $error("error flag moved while disabled");
  a_sys_cfg: assert property (p_sys_cfg) else $error("error flag missed config error");
endmodule

// ==== test_wcts_top.sv ====
// Self-checking testbench of the wake and CAN timeout status block.
`timescale 1ns/10ps

module test_wcts_top;
  localparam int PULSE = 4;
  localparam logic [6:0] A_BUS = wcts_pkg::ADDR_BUS_STATUS;
  localparam logic [6:0] A_WK = wcts_pkg::ADDR_WAKE_SOURCE_FLAGS;
  localparam logic [6:0] A_LV = wcts_pkg::ADDR_WAKE_INPUT_LEVELS;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic restart_rst = 1'b0;
  wcts_pkg::wcts_mode_t mode = wcts_pkg::MODE_NORMAL;
  wcts_pkg::wcts_wake_evt_t evt = '0;
  logic [3:0] lvl = '0, cyc_md = '0, strobe = '0;
  logic en = 1'b0, silent = 1'b0, mask = 1'b0, cfg = 1'b0, err_evt = 1'b0, err_clr = 1'b0;
  wcts_pkg::wcts_acc_req_t acc_req;
  wcts_pkg::wcts_acc_rsp_t acc_rsp;
  logic irq_n, to_flag, sys_err;
  logic [15:0] rd;
  int error_cnt = 0;
  int n_checks = 0;
  logic t_en [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic t_mk [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic t_irq [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  wcts_pkg::wcts_mode_t t_md [5] = '{wcts_pkg::MODE_NORMAL, wcts_pkg::MODE_NORMAL, wcts_pkg::MODE_STOP,
    wcts_pkg::MODE_NORMAL, wcts_pkg::MODE_INIT};

  wcts_top #(.INT_PULSE_CYCLES(PULSE)) wcts_top_inst (
    .clk(clk), .rst_n(rst_n), .restart_rst(restart_rst), .mode(mode), .wake_evt(evt), .wake_level_in(lvl),
    .wake_cyclic_mode(cyc_md), .wake_sample_strobe(strobe), .selective_wake_enable_bit(en),
    .can_silent_indication(silent), .can_timeout_irq_mask(mask), .swk_config_error(cfg),
    .swk_error_event(err_evt), .swk_error_count_clear(err_clr), .acc_req(acc_req), .acc_rsp(acc_rsp),
    .interrupt_out_n(irq_n), .can_timeout_flag(to_flag), .selective_wake_system_error(sys_err));

  wcts_host_model wcts_host_model_inst (.clk(clk), .acc_req(acc_req), .acc_rsp(acc_rsp));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rc(input logic [6:0] a, input logic c, input logic [15:0] exp);
    wcts_host_model_inst.access(a, c, rd);
    chk(rd, exp);
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    rc(A_BUS, 1'b0, 16'h0000);
    rc(A_WK, 1'b0, 16'h0000);
    rc(A_LV, 1'b0, 16'h0000);
    rc(7'h10, 1'b0, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      evt <= 8'(1 << i);
      @(posedge clk);
      evt <= '0;
      rc(A_WK, 1'b0, i < 4 ? 16'(1 << i) : 16'(1 << (i + 3)));
      rc(A_WK, 1'b1, i < 4 ? 16'(1 << i) : 16'(1 << (i + 3)));
      rc(A_WK, 1'b0, 16'h0000);
    end
    @(posedge clk);
    evt <= 8'hff;
    @(posedge clk);
    evt <= '0;
    rc(A_WK, 1'b0, 16'h078f);
    @(posedge clk);
    restart_rst <= 1'b1;
    @(posedge clk);
    restart_rst <= 1'b0;
    rc(A_WK, 1'b1, 16'h0782);
    @(posedge clk);
    evt <= 8'hff;
    @(posedge clk);
    evt <= '0;
    mode <= wcts_pkg::MODE_FAIL_SAFE;
    @(posedge clk);
    mode <= wcts_pkg::MODE_NORMAL;
    rc(A_WK, 1'b0, 16'h0000);
    $display("wake flag test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      mode <= wcts_pkg::wcts_mode_t'(i);
      lvl <= 4'(i + 9);
      rc(A_LV, 1'b0, 16'(i + 9));
    end
    @(posedge clk);
    mode <= wcts_pkg::MODE_SLEEP;
    lvl <= 4'h5;
    rc(A_LV, 1'b0, 16'h000c);
    @(posedge clk);
    cyc_md <= 4'hf;
    mode <= wcts_pkg::MODE_NORMAL;
    lvl <= 4'h6;
    rc(A_LV, 1'b0, 16'h000c);
    @(posedge clk);
    strobe <= 4'hf;
    @(posedge clk);
    strobe <= 4'h0;
    rc(A_LV, 1'b1, 16'h0006);
    rc(A_LV, 1'b0, 16'h0006);
    @(posedge clk);
    cyc_md <= 4'h0;
    $display("level test done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      en <= t_en[i];
      mask <= t_mk[i];
      mode <= t_md[i];
      @(posedge clk);
      silent <= 1'b1;
      @(posedge clk);
      #1;
      chk({15'h0, irq_n}, {15'h0, !t_irq[i]});
      chk({15'h0, to_flag}, {15'h0, t_en[i]});
      @(posedge clk);
      silent <= 1'b0;
      cyc(8);
      rc(A_BUS, 1'b1, t_en[i] ? 16'h0010 : 16'h0000);
      rc(A_BUS, 1'b0, 16'h0000);
    end
    $display("timeout test done");
    // A timeout that sets while a pulse still runs gets no falling edge of its own, so its clear must be refused.
    @(posedge clk);
    mode <= wcts_pkg::MODE_NORMAL;
    silent <= 1'b1;
    @(posedge clk);
    silent <= 1'b0;
    rc(A_BUS, 1'b1, 16'h0010);
    @(posedge clk);
    silent <= 1'b1;
    @(posedge clk);
    silent <= 1'b0;
    rc(A_BUS, 1'b1, 16'h0010);
    rc(A_BUS, 1'b0, 16'h0010);
    chk({15'h0, to_flag}, 16'h0001);
    @(posedge clk);
    restart_rst <= 1'b1;
    @(posedge clk);
    restart_rst <= 1'b0;
    rc(A_BUS, 1'b1, 16'h0010);
    rc(A_BUS, 1'b0, 16'h0000);
    chk({15'h0, to_flag}, 16'h0000);
    $display("clear lock test done");
    @(posedge clk);
    cfg <= 1'b1;
    @(posedge clk);
    cfg <= 1'b0;
    en <= 1'b0;
    rc(A_BUS, 1'b0, 16'h0008);
    chk({15'h0, sys_err}, 16'h0001);
    rc(A_BUS, 1'b1, 16'h0008);
    rc(A_BUS, 1'b0, 16'h0008);
    @(posedge clk);
    en <= 1'b1;
    rc(A_BUS, 1'b1, 16'h0008);
    @(posedge clk);
    en <= 1'b0;
    cfg <= 1'b1;
    @(posedge clk);
    cfg <= 1'b0;
    rc(A_BUS, 1'b0, 16'h0000);
    @(posedge clk);
    en <= 1'b1;
    err_evt <= 1'b1;
    cyc(32);
    err_evt <= 1'b0;
    rc(A_BUS, 1'b0, 16'h0000);
    @(posedge clk);
    err_evt <= 1'b1;
    @(posedge clk);
    err_evt <= 1'b0;
    rc(A_BUS, 1'b0, 16'h0008);
    @(posedge clk);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    rc(A_BUS, 1'b1, 16'h0008);
    rc(A_BUS, 1'b0, 16'h0000);
    $display("error flag test done");
    final_report();
  end

  initial begin
    cyc(5000);
    error_cnt++;
    final_report();
  end
endmodule

bind wcts_top wcts_top_assertions #(.INT_PULSE_CYCLES(INT_PULSE_CYCLES)) wcts_top_assertions_inst (
  .clk(clk), .rst_n(rst_n), .restart_rst(restart_rst), .mode(mode), .acc_req(acc_req), .acc_rsp(acc_rsp),
  .selective_wake_enable_bit(selective_wake_enable_bit), .can_silent_indication(can_silent_indication),
  .can_timeout_irq_mask(can_timeout_irq_mask), .swk_config_error(swk_config_error),
  .interrupt_out_n(interrupt_out_n), .can_timeout_flag(can_timeout_flag),
  .selective_wake_system_error(selective_wake_system_error));
